/* File: include/adc_trig_consts.svh */
// timing, width and code constants for the conversion trigger block
`ifndef ADC_TRIG_CONSTS_SVH
`define ADC_TRIG_CONSTS_SVH

// ****************************************
// widths
// ****************************************
`define RAW_BITS        16
`define RESULT_MAX_BITS 19
`define ACC_BITS        22
`define GAIN_BITS       16
`define GAIN_FRAC_BITS  15
`define GAIN_UNITY      16'h8000
`define OFFSET_RESET    16'h0000

// ****************************************
// oversample ratio select codes
// ****************************************
`define OSR_CODE_1      2'h0
`define OSR_CODE_4      2'h1
`define OSR_CODE_16     2'h2
`define OSR_CODE_64     2'h3

// ****************************************
// timing
// ****************************************
`define CLK_MHZ             100
`define CONVERT_TIME_NS     415
`define AUTOCYCLE_PERIOD_NS 10000
`define CONVERT_CYCLES      16'(((`CONVERT_TIME_NS * `CLK_MHZ) + 999) / 1000)
`define AUTOCYCLE_CYCLES    16'((`AUTOCYCLE_PERIOD_NS * `CLK_MHZ) / 1000)

`endif

/* File: include/adc_trig_pkg.sv */
// types shared by the conversion trigger block
package adc_trig_pkg;

  typedef enum logic [1:0] {
    OSR_X1  = 2'b00,
    OSR_X4  = 2'b01,
    OSR_X16 = 2'b10,
    OSR_X64 = 2'b11
  } osr_e;

  typedef enum logic [0:0] {
    CONV_IDLE = 1'b0,
    CONV_BUSY = 1'b1
  } conv_state_e;

  typedef logic [1:0] lane_shift_t;

endpackage

/* File: hw/result_fifo.sv */
// parameterised result fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module result_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             reset_n_i,
  input  wire logic             ce_i,
  // fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // drain side
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("result_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;

  wire logic full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire logic empty = (wr_ptr == rd_ptr);
  wire logic push  = ce_i && in_valid_i && !full;
  wire logic pop   = ce_i && out_ready_i && !empty;

  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* File: hw/osr_result_formatter.sv */
// oversampling accumulator, offset/gain correction and polarity coding
`timescale 1ns/1ps
`default_nettype none

`include "adc_trig_consts.svh"

module osr_result_formatter (
  // clock and reset
  input  wire logic                         clk_sys_i,
  input  wire logic                         reset_n_i,
  input  wire logic                         ce_i,
  // channel configuration
  input  wire adc_trig_pkg::osr_e           oversample_ratio_i,
  input  wire logic                         bipolar_i,
  input  wire logic signed [15:0]           offset_i,
  input  wire logic [`GAIN_BITS-1:0]        gain_i,
  // raw samples
  input  wire logic                         raw_valid_i,
  input  wire logic [`RAW_BITS-1:0]         raw_data_i,
  output logic                              raw_ready_o,
  // formatted, left-justified results
  output logic                              res_valid_o,
  output logic [`RESULT_MAX_BITS-1:0]       res_data_o,
  input  wire logic                         res_ready_i
);
  import adc_trig_pkg::*;

  logic [`ACC_BITS-1:0] acc;
  logic [6:0]           acc_count;

  // extra bits per result: 0..3 for ratio 1,4,16,64
  wire logic [1:0]  extra_bits = oversample_ratio_i;
  wire logic [6:0]  osr_count  = 7'(7'h01 << {extra_bits, 1'b0});
  wire logic [4:0]  res_bits   = 5'(`RAW_BITS) + {3'h0, extra_bits};
  wire logic [`ACC_BITS-1:0] acc_next = acc + {6'h00, raw_data_i};
  wire logic        last_sample = (acc_count + 7'h01) == osr_count;

  // decimate: sum of 4^e samples shifted down by e
  wire logic [`ACC_BITS-1:0] decimated = acc_next >> extra_bits;

  wire logic [35:0] gained   = 36'(decimated[18:0]) * 36'(gain_i);
  wire logic signed [21:0] corrected =
    $signed({1'b0, gained[35:15]}) + 22'(offset_i);
  wire logic [19:0] code_max = 20'((20'h0_0001 << res_bits) - 20'h0_0001);
  wire logic [19:0] clamped  = corrected < 0 ? 20'h0_0000 :
                               (corrected[20:0] > {1'b0, code_max}) ? code_max :
                               corrected[19:0];
  wire logic [19:0] sign_bit = 20'(20'h0_0001 << (res_bits - 5'h01));
  wire logic [19:0] coded    = bipolar_i ? (clamped ^ sign_bit) : clamped;
  wire logic [`RESULT_MAX_BITS-1:0] justified =
    19'(coded << (5'(`RESULT_MAX_BITS) - res_bits));

  assign raw_ready_o = !res_valid_o;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc         <= '0;
      acc_count   <= '0;
      res_valid_o <= 1'b0;
      res_data_o  <= '0;
    end else if (ce_i) begin
      if (res_valid_o && res_ready_i) begin
        res_valid_o <= 1'b0;
      end
      if (raw_valid_i && !res_valid_o) begin
        if (last_sample) begin
          acc         <= '0;
          acc_count   <= '0;
          res_valid_o <= 1'b1;
          res_data_o  <= justified;
        end else begin
          acc         <= acc_next;
          acc_count   <= acc_count + 7'h01;
        end
      end
    end
  end

endmodule

`default_nettype wire

/* File: hw/adc_convert_trigger_output_format.sv */
// conversion trigger, result formatting and serial output of the converter
`timescale 1ns/1ps
`default_nettype none

`include "adc_trig_consts.svh"

module adc_convert_trigger_output_format #(
  parameter int NUM_CH     = 16,
  parameter int FIFO_DEPTH = 8
) (
  // clock, reset, enable
  input  wire logic                         clk_sys_i,
  input  wire logic                         reset_n_i,
  input  wire logic                         ce_i,
  // mode control
  input  wire logic                         conversion_mode_i,
  input  wire logic                         autocycle_en_i,
  input  wire logic                         dual_lane_i,
  input  wire logic [$clog2(NUM_CH)-1:0]    channel_sel_i,
  // per-channel configuration, channel n at slice n
  input  wire logic [2*NUM_CH-1:0]          oversample_ratio_i,
  input  wire logic [NUM_CH-1:0]            bipolar_i,
  input  wire logic [16*NUM_CH-1:0]         offset_i,
  input  wire logic [16*NUM_CH-1:0]         gain_i,
  // converter core
  input  wire logic [`RAW_BITS-1:0]         raw_data_i,
  output logic                              sample_strobe_o,
  // pins
  input  wire logic                         convert_start_input_i,
  input  wire logic                         spi_sck_i,
  input  wire logic                         spi_cs_n_i,
  output logic                              primary_serial_out_o,
  output logic                              primary_serial_oe_o,
  output logic                              busy_alert_multipurpose_pin_o,
  output logic                              busy_alert_multipurpose_pin_oe_o,
  // status
  output logic                              busy_o,
  output logic                              result_pending_o
);
  import adc_trig_pkg::*;

  if (NUM_CH < 2 || NUM_CH > 16) begin : g_bad_ch
    $error("channel count must lie between 2 and 16");
  end

  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end

  // the timer must outlast a conversion, or ticks are lost while busy
  if (`AUTOCYCLE_CYCLES <= `CONVERT_CYCLES || `CONVERT_CYCLES < 16'h0002) begin : g_bad_timing
    $error("autocycle period must exceed the conversion time");
  end

  // ****************************************
  // helper functions
  // ****************************************
  // level high now, low one cycle before
  function automatic logic went_high(input logic now_level, input logic old_level);
    return now_level && !old_level;
  endfunction

  // level low now, high one cycle before
  function automatic logic went_low(input logic now_level, input logic old_level);
    return !now_level && old_level;
  endfunction

  // one channel's 16-bit field out of a packed per-channel bus
  function automatic logic [15:0] chan_word(input logic [16*NUM_CH-1:0]        bus,
                                            input logic [$clog2(NUM_CH)-1:0] ch);
    return bus[16*ch +: 16];
  endfunction

  // one channel's 2-bit ratio code out of the packed ratio bus
  function automatic logic [1:0] chan_ratio(input logic [2*NUM_CH-1:0]         bus,
                                            input logic [$clog2(NUM_CH)-1:0] ch);
    return bus[2*ch +: 2];
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] cnv_sync;
  logic [1:0] sck_sync;
  logic [1:0] cs_sync;
  logic       cnv_prev;
  logic       sck_prev;
  logic       cs_prev;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnv_sync <= 2'b00;
      sck_sync <= 2'b11;
      cs_sync  <= 2'b11;
      cnv_prev <= 1'b0;
      sck_prev <= 1'b1;
      cs_prev  <= 1'b1;
    end else if (ce_i) begin
      cnv_sync <= {cnv_sync[0], convert_start_input_i};
      sck_sync <= {sck_sync[0], spi_sck_i};
      cs_sync  <= {cs_sync[0], spi_cs_n_i};
      cnv_prev <= cnv_sync[1];
      sck_prev <= sck_sync[1];
      cs_prev  <= cs_sync[1];
    end
  end

  wire logic cnv_rise  = went_high(cnv_sync[1], cnv_prev);
  wire logic cs_fall   = went_low(cs_sync[1], cs_prev);
  wire logic cs_active = !cs_sync[1];
  // mode 3: idle high, data changes on falling edge
  wire logic sck_fall  = went_low(sck_sync[1], sck_prev) && cs_active;

  // ****************************************
  // autocycle timer
  // ****************************************
  logic [15:0] auto_count;
  wire logic   auto_run  = conversion_mode_i && autocycle_en_i;
  wire logic   auto_tick = auto_run && (auto_count == `AUTOCYCLE_CYCLES - 16'h0001);

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      auto_count <= 16'h0000;
    end else if (ce_i) begin
      if (!auto_run || auto_tick) begin
        auto_count <= 16'h0000;
      end else begin
        auto_count <= auto_count + 16'h0001;
      end
    end
  end

  // ****************************************
  // trigger selection
  // ****************************************
  // pin edges count only in conversion mode without autocycle
  wire logic pin_trigger = conversion_mode_i && !autocycle_en_i && cnv_rise;
  wire logic trigger_src = autocycle_en_i ? auto_tick : pin_trigger;

  // ****************************************
  // channel configuration select
  // ****************************************
  // a select past the last channel falls back to channel 0
  wire logic [$clog2(NUM_CH)-1:0] sel_ch =
    (32'(channel_sel_i) < NUM_CH) ? channel_sel_i : '0;
  wire osr_e        sel_osr    = osr_e'(chan_ratio(oversample_ratio_i, sel_ch));
  wire logic        sel_bipol  = bipolar_i[sel_ch];
  wire logic [15:0] sel_offset = chan_word(offset_i, sel_ch);
  wire logic [15:0] sel_gain   = chan_word(gain_i, sel_ch);

  // ****************************************
  // conversion sequencer
  // ****************************************
  conv_state_e state;
  conv_state_e next_state;
  logic [15:0] conv_count;
  logic        raw_valid;
  logic        raw_ready;

  // a trigger while busy or while results back up is dropped
  wire logic trigger_ok = trigger_src && (state == CONV_IDLE) && raw_ready;
  wire logic conv_done  = (state == CONV_BUSY) && (conv_count == `CONVERT_CYCLES - 16'h0001);
  // busy rises with the sample and falls as the conversion ends
  wire logic next_busy  = trigger_ok || (busy_o && !conv_done);

  always_comb begin
    next_state = state;
    unique case (state)
      CONV_IDLE: begin
        if (trigger_ok) begin
          next_state = CONV_BUSY;
        end
      end
      CONV_BUSY: begin
        if (conv_done) begin
          next_state = CONV_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state           <= CONV_IDLE;
      conv_count      <= 16'h0000;
      sample_strobe_o <= 1'b0;
      raw_valid       <= 1'b0;
    end else if (ce_i) begin
      state           <= next_state;
      sample_strobe_o <= trigger_ok;
      raw_valid       <= conv_done;
      conv_count      <= (state == CONV_BUSY) ? conv_count + 16'h0001 : 16'h0000;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_o <= 1'b0;
    end else if (ce_i) begin
      busy_o <= next_busy;
    end
  end

  // ****************************************
  // formatting and buffering
  // ****************************************
  logic                        res_valid;
  logic [`RESULT_MAX_BITS-1:0] res_data;
  logic                        res_ready;
  logic                        fifo_valid;
  logic [`RESULT_MAX_BITS-1:0] fifo_data;

  // accumulates ratio samples before a result appears
  osr_result_formatter u_formatter (
    .clk_sys_i          (clk_sys_i),
    .reset_n_i          (reset_n_i),
    .ce_i               (ce_i),
    .oversample_ratio_i (sel_osr),
    .bipolar_i          (sel_bipol),
    .offset_i           ($signed(sel_offset)),
    .gain_i             (sel_gain),
    .raw_valid_i        (raw_valid),
    .raw_data_i         (raw_data_i),
    .raw_ready_o        (raw_ready),
    .res_valid_o        (res_valid),
    .res_data_o         (res_data),
    .res_ready_i        (res_ready)
  );

  result_fifo #(
    .WIDTH (`RESULT_MAX_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .reset_n_i   (reset_n_i),
    .ce_i        (ce_i),
    .in_valid_i  (res_valid),
    .in_data_i   (res_data),
    .in_ready_o  (res_ready),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_data),
    .out_ready_i (cs_fall)
  );

  // ****************************************
  // serial output shifter
  // ****************************************
  logic [`RESULT_MAX_BITS:0] shreg;
  wire lane_shift_t lane_step = dual_lane_i ? 2'd2 : 2'd1;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shreg <= '0;
    end else if (ce_i) begin
      if (cs_fall) begin
        // no result ready: the frame carries zeros
        shreg <= fifo_valid ? {fifo_data, 1'b0} : '0;
      end else if (sck_fall) begin
        shreg <= shreg << lane_step;
      end
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  wire logic next_primary   = cs_active ? shreg[`RESULT_MAX_BITS] : 1'b0;
  wire logic data_on_multi  = dual_lane_i && cs_active;
  wire logic next_multi     = data_on_multi ? shreg[`RESULT_MAX_BITS-1] : busy_o;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      primary_serial_out_o             <= 1'b0;
      primary_serial_oe_o              <= 1'b0;
      busy_alert_multipurpose_pin_o    <= 1'b0;
      busy_alert_multipurpose_pin_oe_o <= 1'b0;
      result_pending_o                 <= 1'b0;
    end else if (ce_i) begin
      primary_serial_out_o             <= next_primary;
      primary_serial_oe_o              <= cs_active;
      busy_alert_multipurpose_pin_o    <= next_multi;
      busy_alert_multipurpose_pin_oe_o <= 1'b1;
      result_pending_o                 <= fifo_valid;
    end
  end

endmodule

`default_nettype wire

/* File: test/adc_host_spi_model.sv */
// host spi controller model: convert start pulses and mode 3 frames
`timescale 1ns/1ps
`default_nettype none

module adc_host_spi_model (
  // lines from the converter
  input  wire logic dual_i,
  input  wire logic busy_i,
  input  wire logic miso0_i,
  input  wire logic miso1_i,
  // host outputs
  output logic      cnv_o,
  output logic      sck_o,
  output logic      cs_n_o
);
  initial begin
    cnv_o  = 1'b0;
    sck_o  = 1'b1;
    cs_n_o = 1'b1;
  end

  // fixed period keeps frames synchronous to convert start
  task automatic pulse_cnv();
    #3;
    cnv_o = 1'b1;
    #100;
    cnv_o = 1'b0;
    #500;
  endtask

  // sck runs only inside the frame, sampled at the end of each high phase
  task automatic read_frame(output logic [18:0] word, output bit late);
    int k;
    int n;
    int g;
    word = 19'h0_0000;
    g = 0;
    while (busy_i !== 1'b0 && g < 200) begin
      #10;
      g++;
    end
    late = (busy_i !== 1'b0);
    n = dual_i ? 10 : 19;
    cs_n_o = 1'b0;
    #100;
    for (k = 0; k < n; k++) begin
      if (k > 0) begin
        sck_o = 1'b0;
        #62.5;
        sck_o = 1'b1;
        #62.5;
      end
      if (dual_i) begin
        word[18-2*k] = miso0_i;
        if (k < 9) word[17-2*k] = miso1_i;
      end else begin
        word[18-k] = miso0_i;
      end
    end
    #50;
    cs_n_o = 1'b1;
    #300;
  endtask
endmodule

`default_nettype wire

/* File: test/adc_convert_trigger_output_format_assertions.sv */
// assertion checker for the conversion trigger block
`timescale 1ns/1ps
`default_nettype none

`include "adc_trig_consts.svh"

module adc_convert_trigger_output_format_checker (
  // clock, reset, modes
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic conversion_mode_i,
  input wire logic autocycle_en_i,
  input wire logic dual_lane_i,
  // pins and status
  input wire logic convert_start_input_i,
  input wire logic spi_cs_n_i,
  input wire logic sample_strobe_o,
  input wire logic busy_o,
  input wire logic primary_serial_oe_o,
  input wire logic busy_alert_multipurpose_pin_o,
  input wire logic busy_alert_multipurpose_pin_oe_o
);
  localparam int CONV_CYC = `CONVERT_CYCLES;
  int busy_len;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  // length of the current busy phase
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_len <= 0;
    end else if (!busy_o) begin
      busy_len <= 0;
    end else if (ce_i) begin
      busy_len <= busy_len + 1;
    end
  end

  sequence s_launch;
    sample_strobe_o && busy_o;
  endsequence

  sequence s_cs_idle;
    spi_cs_n_i [*8];
  endsequence

  strobe_single_a : assert property (sample_strobe_o |=> !sample_strobe_o)
    else $error("strobe wider than one cycle");
  busy_start_a : assert property ($rose(busy_o) |-> s_launch)
    else $error("busy rose without a sample");
  busy_len_a : assert property ($fell(busy_o) |-> busy_len == CONV_CYC)
    else $error("busy phase length wrong");
  no_retrig_a : assert property (busy_o && $past(busy_o) |-> !sample_strobe_o)
    else $error("sample taken while busy");
  reg_mode_a : assert property (
    (!conversion_mode_i && !autocycle_en_i) [*5] |-> !sample_strobe_o)
    else $error("sample taken in register mode");
  cnv_cause_a : assert property (
    sample_strobe_o && !$past(autocycle_en_i) |-> $past(convert_start_input_i))
    else $error("sample without convert start");
  oe_idle_a : assert property (s_cs_idle |-> !primary_serial_oe_o)
    else $error("primary output driven outside frame");
  oe_active_a : assert property ($fell(spi_cs_n_i) |-> ##[2:8] primary_serial_oe_o)
    else $error("primary output not driven in frame");
  single_lane_a : assert property (!dual_lane_i && $past(!dual_lane_i) |->
    busy_alert_multipurpose_pin_o == $past(busy_o))
    else $error("multipurpose pin not busy in single lane");
  pin_oe_a : assert property ($past(reset_n_i) |-> busy_alert_multipurpose_pin_oe_o)
    else $error("multipurpose pin released");
endmodule

bind adc_convert_trigger_output_format adc_convert_trigger_output_format_checker u_chk (.*);

`default_nettype wire

/* File: test/adc_convert_trigger_output_format_tb.sv */
// self-checking bench for the conversion trigger block
`timescale 1ns/1ps
`default_nettype none

`include "adc_trig_consts.svh"

module adc_convert_trigger_output_format_tb;
  import adc_trig_pkg::*;
  localparam int CH = 3;
  // ****************************************
  // signals
  // ****************************************
  logic         clk_sys_i = 1'b0;
  logic         reset_n_i = 1'b0;
  logic         ce_i = 1'b1;
  logic         conversion_mode_i = 1'b1;
  logic         autocycle_en_i = 1'b0;
  logic         dual_lane_i = 1'b0;
  logic [3:0]   channel_sel_i = 4'(CH);
  logic [31:0]  oversample_ratio_i = 32'h0000_0000;
  logic [15:0]  bipolar_i = 16'h0000;
  logic [255:0] offset_i = 256'h0;
  logic [255:0] gain_i = {16{`GAIN_UNITY}};
  logic [15:0]  raw_data_i = 16'h0000;
  logic         convert_start_input_i;
  logic         spi_sck_i;
  logic         spi_cs_n_i;
  logic         sample_strobe_o;
  logic         primary_serial_out_o;
  logic         primary_serial_oe_o;
  logic         busy_alert_multipurpose_pin_o;
  logic         busy_alert_multipurpose_pin_oe_o;
  logic         busy_o;
  logic         result_pending_o;
  logic         miso0;
  logic         miso1;
  int           fails = 0;
  int           n_compared = 0;
  int           strobes = 0;

  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (sample_strobe_o === 1'b1) strobes++;
  // released lines sit at the pull-up level
  assign miso0 = primary_serial_oe_o ? primary_serial_out_o : 1'b1;
  assign miso1 = busy_alert_multipurpose_pin_oe_o ? busy_alert_multipurpose_pin_o : 1'b1;

  adc_convert_trigger_output_format #(.NUM_CH(16), .FIFO_DEPTH(8)) dut (.*);

  adc_host_spi_model host (
    .dual_i  (dual_lane_i),
    .busy_i  (miso1),
    .miso0_i (miso0),
    .miso1_i (miso1),
    .cnv_o   (convert_start_input_i),
    .sck_o   (spi_sck_i),
    .cs_n_o  (spi_cs_n_i)
  );

  // ****************************************
  // tasks
  // ****************************************
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check_word(input logic [18:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, exp);
    check_word({18'h0_0000, got}, {18'h0_0000, exp});
  endtask

  task automatic set_ch(input logic [1:0] o, input logic b, input logic [15:0] f, g);
    @(negedge clk_sys_i);
    oversample_ratio_i[2*CH +: 2] = o;
    bipolar_i[CH] = b;
    offset_i[16*CH +: 16] = f;
    gain_i[16*CH +: 16] = g;
  endtask

  task automatic convert(input logic [15:0] r);
    int g;
    @(negedge clk_sys_i);
    raw_data_i = r;
    host.pulse_cnv();
    g = 0;
    while (busy_o !== 1'b0 && g < 100) begin
      @(negedge clk_sys_i);
      g++;
    end
    if (g == 100) begin
      fails++;
      results();
    end
  endtask

  task automatic frame(input logic [18:0] exp);
    logic [18:0] w;
    bit          late;
    host.read_frame(w, late);
    if (late) begin
      fails++;
      results();
    end else begin
      check_word(w, exp);
    end
  endtask

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    int i;
    int e;
    int k;
    int s0;
    logic [18:0] w;
    bit late;
    repeat (16) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    frame(19'h0_0000);
    s0 = strobes;
    convert(16'hA5C3);
    check_flag(strobes - s0 == 1, 1'b1);
    frame({16'hA5C3, 3'h0});
    set_ch(OSR_X1, 1'b1, 16'h0000, `GAIN_UNITY);
    convert(16'hA5C3);
    frame({16'h25C3, 3'h0});
    set_ch(OSR_X1, 1'b0, 16'h0010, 16'h4000);
    convert(16'h2000);
    frame({16'h1010, 3'h0});
    for (e = 1; e < 4; e++) begin
      set_ch(2'(e), 1'b0, 16'h0000, `GAIN_UNITY);
      for (i = 0; i < (1 << (2 * e)); i++) begin
        convert(16'h1234);
        check_flag(result_pending_o, i == (1 << (2 * e)) - 1);
        if (i == 0) frame(19'h0_0000);
      end
      frame({16'h1234, 3'h0});
    end
    set_ch(OSR_X1, 1'b0, 16'h0000, `GAIN_UNITY);
    dual_lane_i = 1'b1;
    convert(16'hC3A5);
    frame({16'hC3A5, 3'h0});
    @(negedge clk_sys_i);
    dual_lane_i = 1'b0;
    conversion_mode_i = 1'b0;
    s0 = strobes;
    host.pulse_cnv();
    check_flag(strobes == s0, 1'b1);
    @(negedge clk_sys_i);
    conversion_mode_i = 1'b1;
    s0 = strobes;
    for (i = 0; i < 12; i++) convert(16'(16'h0100 + i));
    k = strobes - s0;
    check_word(19'(k), 19'h0_0009);
    for (i = 0; i < k; i++) frame({16'(16'h0100 + i), 3'h0});
    check_flag(result_pending_o, 1'b0);
    @(negedge clk_sys_i);
    raw_data_i = 16'h0F0F;
    autocycle_en_i = 1'b1;
    s0 = strobes;
    repeat (40) host.pulse_cnv();
    check_flag(strobes - s0 inside {[2:3]}, 1'b1);
    frame({16'h0F0F, 3'h0});
    @(negedge clk_sys_i);
    autocycle_en_i = 1'b0;
    for (i = 0; i < 10 && result_pending_o === 1'b1; i++) begin
      host.read_frame(w, late);
      fails += late;
    end
    check_flag(result_pending_o, 1'b0);
    results();
  end
endmodule

`default_nettype wire
